/* File: rtl/cbt_defs.svh */
// register offsets, field positions and reset values of the bit timing block
`ifndef CBT_DEFS_SVH
`define CBT_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CBT_OFS_CTRL            8'h00
`define CBT_OFS_STAT            8'h01
`define CBT_OFS_BTR0            8'h02
`define CBT_OFS_BTR1            8'h03
`define CBT_OFS_RFLG            8'h04
`define CBT_OFS_RIER            8'h05

// ----------------------------------------
// field positions
// ----------------------------------------
`define CBT_CTRL_INIT_REQ_BIT   0
`define CBT_CTRL_CLK_SEL_BIT    1
`define CBT_STAT_INIT_ACK_BIT   0
`define CBT_RFLG_WAKE_BIT       7
`define CBT_RFLG_STCH_BIT       6
`define CBT_RFLG_OVR_BIT        1
`define CBT_RFLG_FULL_BIT       0
`define CBT_RFLG_FLAG_MASK      8'hC3

// ----------------------------------------
// reset values
// ----------------------------------------
`define CBT_CTRL_RESET          1'h0
`define CBT_BTR_RESET           8'h00
`define CBT_RFLG_RESET          8'h00
`define CBT_RIER_RESET          8'h00
`define CBT_SMP_RESET           3'h7

`endif

/* File: rtl/cbt_pkg.sv */
// types shared by the bit timing block
package cbt_pkg;

	// segment sequencer, gray along sync, seg1, seg2
	typedef enum logic [1:0] {
		CBT_SYNC = 2'b00,
		CBT_SEG1 = 2'b01,
		CBT_SEG2 = 2'b11
	} cbt_seg_t;

	typedef struct packed {
		logic [1:0] jump_width;
		logic [5:0] quantum_prescaler;
	} cbt_btr0_t;

	typedef struct packed {
		logic       triple_sample_select;
		logic [2:0] segment_two_length;
		logic [3:0] segment_one_length;
	} cbt_btr1_t;

	typedef struct packed {
		cbt_btr0_t pj;
		cbt_btr1_t ss;
	} cbt_timing_t;

	typedef struct packed {
		logic       wakeup_flag;
		logic       status_change_flag;
		logic [1:0] receiver_state;
		logic [1:0] transmitter_state;
		logic       overrun_flag;
		logic       receive_full_flag;
	} cbt_rflg_t;

endpackage

/* File: rtl/cbt_bit_timer.sv */
// quantum prescaler, segment sequencer and bus sampling
`timescale 1ns/100ps
`default_nettype none
`include "cbt_defs.svh"
module cbt_bit_timer
	import cbt_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// control
	input  wire logic        run,
	input  wire logic        ctrl_tick,
	input  wire cbt_timing_t cfg,
	// bus
	input  wire logic        can_rx,
	// timing outputs
	output logic             tq_tick,
	output logic             sample_point,
	output logic             bit_start,
	output logic             rx_bit
);

	logic [5:0] pre_cnt_r;
	logic       tq_r;
	logic       sp_r;
	logic       bs_r;
	logic       bit_r;
	logic [2:0] smp_r;
	cbt_seg_t   st_r;
	logic [4:0] cnt_r;
	logic [4:0] ext_r;
	logic [4:0] cut_r;
	logic       resync_r;
	logic [4:0] seg1_len;
	logic [4:0] seg2_len;
	logic [4:0] sjw_q;
	logic [4:0] late_w;
	logic [4:0] ext_n;
	logic [4:0] rem_w;
	logic [4:0] ext_use;
	logic [4:0] cut_use;
	logic       edge_w;
	logic       maj_w;

	// ----------------------------------------
	// prescaler
	// ----------------------------------------
	// divisor is field plus one
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_r <= 6'h00;
		end else if (!run) begin
			pre_cnt_r <= 6'h00;
		end else if (ctrl_tick) begin
			if (pre_cnt_r == cfg.pj.quantum_prescaler) begin
				pre_cnt_r <= 6'h00;
			end else begin
				pre_cnt_r <= pre_cnt_r + 6'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tq_r <= 1'b0;
		end else begin
			tq_r <= run & ctrl_tick &
				(pre_cnt_r == cfg.pj.quantum_prescaler);
		end
	end

	// ----------------------------------------
	// segment lengths and resync terms
	// ----------------------------------------
	// seg1 field plus one quanta
	assign seg1_len = {1'b0, cfg.ss.segment_one_length} + 5'h01;
	assign seg2_len = {2'b00, cfg.ss.segment_two_length} + 5'h01;
	assign sjw_q    = {3'b000, cfg.pj.jump_width} + 5'h01;
	assign late_w   = cnt_r + 5'h01;
	assign ext_n    = (late_w > sjw_q) ? sjw_q : late_w;
	assign rem_w    = seg2_len - cnt_r;
	// only recessive to dominant edges resync, once per bit
	assign edge_w   = tq_r & smp_r[0] & ~can_rx & ~resync_r;
	assign ext_use  = edge_w ? ext_n : ext_r;
	assign cut_use  = edge_w ? sjw_q : cut_r;
	// earlier samples stay in seg1 when it is 3 quanta or more
	assign maj_w    = (smp_r[1] & smp_r[0]) | (smp_r[1] & can_rx) |
		(smp_r[0] & can_rx);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			smp_r <= `CBT_SMP_RESET;
		end else if (tq_r) begin
			smp_r <= {smp_r[1:0], can_rx};
		end
	end

	// ----------------------------------------
	// segment sequencer
	// ----------------------------------------
	// bit is sync plus seg1 plus seg2 quanta
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r     <= CBT_SYNC;
			cnt_r    <= 5'h00;
			ext_r    <= 5'h00;
			cut_r    <= 5'h00;
			resync_r <= 1'b0;
			sp_r     <= 1'b0;
			bs_r     <= 1'b0;
			bit_r    <= 1'b1;
		end else begin
			sp_r <= 1'b0;
			bs_r <= 1'b0;
			if (!run) begin
				st_r     <= CBT_SYNC;
				cnt_r    <= 5'h00;
				ext_r    <= 5'h00;
				cut_r    <= 5'h00;
				resync_r <= 1'b0;
			end else if (tq_r) begin
				case (st_r)
				CBT_SYNC: begin
					st_r     <= CBT_SEG1;
					cnt_r    <= 5'h00;
					ext_r    <= 5'h00;
					cut_r    <= 5'h00;
					resync_r <= 1'b0;
					bs_r     <= 1'b1;
				end
				CBT_SEG1: begin
					if (edge_w) begin
						ext_r    <= ext_n;
						resync_r <= 1'b1;
					end
					if (late_w >= seg1_len + ext_use) begin
						st_r  <= CBT_SEG2;
						cnt_r <= 5'h00;
						sp_r  <= 1'b1;
						bit_r <= cfg.ss.triple_sample_select ?
							maj_w : can_rx;
					end else begin
						cnt_r <= late_w;
					end
				end
				CBT_SEG2: begin
					// early edge shortens seg2 by sjw
					if (edge_w && rem_w <= sjw_q) begin
						st_r     <= CBT_SEG1;
						cnt_r    <= 5'h00;
						ext_r    <= 5'h00;
						cut_r    <= 5'h00;
						resync_r <= 1'b1;
						bs_r     <= 1'b1;
					end else begin
						if (edge_w) begin
							cut_r    <= sjw_q;
							resync_r <= 1'b1;
						end
						if (late_w + cut_use >= seg2_len) begin
							st_r  <= CBT_SYNC;
							cnt_r <= 5'h00;
						end else begin
							cnt_r <= late_w;
						end
					end
				end
				default: begin
					st_r <= CBT_SYNC;
				end
				endcase
			end
		end
	end

	assign tq_tick      = tq_r;
	assign sample_point = sp_r;
	assign bit_start    = bs_r;
	assign rx_bit       = bit_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_prescale_range: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		run |-> pre_cnt_r <= cfg.pj.quantum_prescaler)
		else $error("prescaler count beyond divisor");

	a_tq_spacing: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		tq_r && cfg.pj.quantum_prescaler != 6'h00 |=> !tq_r)
		else $error("quantum ticks too close");

	a_single_sample: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		sp_r && !cfg.ss.triple_sample_select |->
		bit_r == $past(can_rx))
		else $error("single sample value wrong");

	a_majority_vote: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		sp_r && cfg.ss.triple_sample_select |->
		bit_r == $past(maj_w))
		else $error("majority vote wrong");

	// seg1 may stretch by the jump width and no further
	a_jump_limit: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		ext_r <= sjw_q && cut_r <= sjw_q &&
		(st_r != CBT_SEG1 || cnt_r < seg1_len + sjw_q))
		else $error("resync beyond jump width");

	a_seg2_bound: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		st_r == CBT_SEG2 |-> cnt_r < seg2_len)
		else $error("seg2 overran its length");

	c_triple_point: cover property (
		@(posedge sys_clk) disable iff (!rst_n)
		sp_r && cfg.ss.triple_sample_select);

	c_late_resync: cover property (
		@(posedge sys_clk) disable iff (!rst_n)
		edge_w && st_r == CBT_SEG1);

endmodule
`default_nettype wire

/* File: rtl/cbt_bit_timing_config.sv */
// bit timing configuration, receiver flags and register port
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cbt_defs.svh"
module cbt_bit_timing_config
	import cbt_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// clock source and bus
	input  wire logic       osc_tick,
	input  wire logic       can_rx,
	// receiver events
	input  wire logic       wakeup_evt,
	input  wire logic       status_change_evt,
	input  wire logic       overrun_evt,
	input  wire logic       rx_full_evt,
	input  wire logic [1:0] rx_state_in,
	input  wire logic [1:0] tx_state_in,
	// status outputs
	output logic            irq,
	output logic            init_mode,
	// timing outputs
	output logic            tq_tick,
	output logic            sample_point,
	output logic            bit_start,
	output logic            rx_bit
);

	logic        rst_m_r;
	logic        rst_n_r;
	logic        init_req_r;
	logic        clk_sel_r;
	logic        init_ack_r;
	logic        init_mode_r;
	cbt_btr0_t   btr0_r;
	cbt_btr1_t   btr1_r;
	logic [7:0]  rier_r;
	logic [3:0]  fl_r;
	logic [1:0]  rx_state_r;
	logic [1:0]  tx_state_r;
	logic        irq_r;
	logic [7:0]  rdata_r;
	logic        init_act;
	logic        wr_ctrl;
	logic        wr_btr0;
	logic        wr_btr1;
	logic        wr_rflg;
	logic        wr_rier;
	logic        ctrl_tick;
	logic [3:0]  ev_w;
	logic [3:0]  clr_w;
	cbt_rflg_t   rflg_w;
	cbt_timing_t cfg_w;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_m_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_n_r <= rst_m_r;
		end
	end

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	assign wr_ctrl = reg_wr & (reg_addr == `CBT_OFS_CTRL);
	assign wr_btr0 = reg_wr & (reg_addr == `CBT_OFS_BTR0);
	assign wr_btr1 = reg_wr & (reg_addr == `CBT_OFS_BTR1);
	assign wr_rflg = reg_wr & (reg_addr == `CBT_OFS_RFLG);
	assign wr_rier = reg_wr & (reg_addr == `CBT_OFS_RIER);

	// ----------------------------------------
	// initialization handshake
	// ----------------------------------------
	// mode needs request and acknowledge
	assign init_act = init_req_r & init_ack_r;

	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			init_req_r <= `CBT_CTRL_RESET;
		end else if (wr_ctrl) begin
			init_req_r <= reg_wdata[`CBT_CTRL_INIT_REQ_BIT];
		end
	end

	// source may only change while the prescaler is held
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			clk_sel_r <= `CBT_CTRL_RESET;
		end else if (wr_ctrl && init_act) begin
			clk_sel_r <= reg_wdata[`CBT_CTRL_CLK_SEL_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			init_ack_r  <= 1'b0;
			init_mode_r <= 1'b0;
		end else begin
			init_ack_r  <= init_req_r;
			init_mode_r <= init_act;
		end
	end

	// ----------------------------------------
	// timing registers
	// ----------------------------------------
	// written only in initialization mode
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			btr0_r <= `CBT_BTR_RESET;
		end else if (wr_btr0 && init_act) begin
			btr0_r <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			btr1_r <= `CBT_BTR_RESET;
		end else if (wr_btr1 && init_act) begin
			btr1_r <= reg_wdata;
		end
	end

	assign cfg_w = {btr0_r, btr1_r};

	// ----------------------------------------
	// receiver flags
	// ----------------------------------------
	assign ev_w  = {wakeup_evt, status_change_evt, overrun_evt, rx_full_evt};
	assign clr_w = {reg_wdata[`CBT_RFLG_WAKE_BIT],
		reg_wdata[`CBT_RFLG_STCH_BIT],
		reg_wdata[`CBT_RFLG_OVR_BIT],
		reg_wdata[`CBT_RFLG_FULL_BIT]};

	// flags are held cleared while initialization mode lasts
	generate
		for (genvar i = 0; i < 4; i++) begin : g_flag
			// clear only once the cause is gone
			always_ff @(posedge sys_clk or negedge rst_n_r) begin
				if (!rst_n_r) begin
					fl_r[i] <= 1'b0;
				end else if (init_act) begin
					fl_r[i] <= 1'b0;
				end else if (ev_w[i]) begin
					fl_r[i] <= 1'b1;
				end else if (wr_rflg && clr_w[i]) begin
					fl_r[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// pending status change freezes the state bits
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rx_state_r <= 2'h0;
			tx_state_r <= 2'h0;
		end else if (!fl_r[2]) begin
			rx_state_r <= rx_state_in;
			tx_state_r <= tx_state_in;
		end
	end

	assign rflg_w = {fl_r[3], fl_r[2], rx_state_r, tx_state_r,
		fl_r[1], fl_r[0]};

	// ----------------------------------------
	// interrupt
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rier_r <= `CBT_RIER_RESET;
		end else if (wr_rier) begin
			rier_r <= reg_wdata;
		end
	end

	// each flag gated by its enable
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(rflg_w & rier_r & `CBT_RFLG_FLAG_MASK);
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// timing registers readable anytime
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`CBT_OFS_CTRL: rdata_r <= {6'h00, clk_sel_r, init_req_r};
			`CBT_OFS_STAT: rdata_r <= {7'h00, init_ack_r};
			`CBT_OFS_BTR0: rdata_r <= btr0_r;
			`CBT_OFS_BTR1: rdata_r <= btr1_r;
			`CBT_OFS_RFLG: rdata_r <= rflg_w;
			`CBT_OFS_RIER: rdata_r <= rier_r;
			default:       rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// ----------------------------------------
	// bit timer
	// ----------------------------------------
	// oscillator ticks or every bus cycle
	assign ctrl_tick = clk_sel_r | osc_tick;

	cbt_bit_timer u_timer (
		.sys_clk      (sys_clk),
		.rst_n        (rst_n_r),
		.run          (~init_act),
		.ctrl_tick    (ctrl_tick),
		.cfg          (cfg_w),
		.can_rx       (can_rx),
		.tq_tick      (tq_tick),
		.sample_point (sample_point),
		.bit_start    (bit_start),
		.rx_bit       (rx_bit)
	);

	assign reg_rdata = rdata_r;
	assign irq       = irq_r;
	assign init_mode = init_mode_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_btr_locked: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		wr_btr0 && !init_act |=> btr0_r == $past(btr0_r))
		else $error("timing write taken outside init");

	a_btr_written: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		wr_btr1 && init_act |=> btr1_r == $past(reg_wdata))
		else $error("timing write lost in init");

	a_btr_readback: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		reg_rd && reg_addr == `CBT_OFS_BTR0 |=>
		reg_rdata == $past(btr0_r))
		else $error("timing readback wrong");

	a_flag_w1c: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		wr_rflg && reg_wdata[`CBT_RFLG_FULL_BIT] && !rx_full_evt |=>
		!fl_r[0])
		else $error("write one did not clear flag");

	a_flag_zero_write: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		wr_rflg && !reg_wdata[`CBT_RFLG_OVR_BIT] && fl_r[1] &&
		!init_act |=> fl_r[1])
		else $error("write zero changed flag");

	a_flag_set_wins: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		wakeup_evt && !init_act |=> fl_r[3] [*1] ##0
		rflg_w.wakeup_flag)
		else $error("flag lost while cause present");

	a_irq_gating: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		##1 irq_r == $past(|(rflg_w & rier_r & `CBT_RFLG_FLAG_MASK)))
		else $error("interrupt not gated by enables");

	a_init_handshake: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		$rose(init_req_r) |=> init_ack_r ##1 init_mode_r)
		else $error("init acknowledge missing");

	a_state_hold: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		fl_r[2] |=> $stable(rx_state_r) && $stable(tx_state_r))
		else $error("state moved under pending change");

	c_flag_irq: cover property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_full_evt ##1 rier_r[0] && fl_r[0] ##1 irq_r);

	c_init_write: cover property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		wr_btr1 && init_act ##1 !init_req_r);

endmodule
`default_nettype wire

/* File: sim/cbt_bus_node.sv */
// far side bus node model driving the receive line
`timescale 1ns/100ps
`default_nettype none
module cbt_bus_node (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// 0 idle recessive, 1 dominant, 2 one-in-three glitch pattern
	input  wire logic [1:0] mode,
	// bus
	output logic            can_rx
);
	logic [2:0] ph_r;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ph_r <= 3'h0;
		else
			ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
	end

	// pattern high 2 of every 6 cycles: hits one of any three quanta samples
	assign can_rx = (mode == 2'h0) ? 1'b1 :
			(mode == 2'h1) ? 1'b0 : (ph_r < 3'h2);
endmodule
`default_nettype wire

/* File: sim/cbt_bit_timing_config_test.sv */
// self-checking bench for the bit timing configuration block
`timescale 1ns/100ps
`default_nettype none
module cbt_bit_timing_config_test;
	import cbt_pkg::*;

	logic       sys_clk = 1'b0;
	logic       reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic       osc_tick = 1'b0;
	logic [1:0] osc_cnt = 2'h0;
	logic       can_rx;
	logic [1:0] bus_mode = 2'h0;
	logic       wakeup_evt = 1'b0;
	logic       status_change_evt = 1'b0;
	logic       overrun_evt = 1'b0;
	logic       rx_full_evt = 1'b0;
	logic [1:0] rx_state_in = 2'h0;
	logic [1:0] tx_state_in = 2'h0;
	logic       irq, init_mode, tq_tick, sample_point, bit_start, rx_bit;
	int         error_cnt = 0;
	int         total_checks = 0;
	int         cyc = 0;
	logic [7:0] n;

	always #5 sys_clk = ~sys_clk;

	// oscillator source: one enable every third cycle
	always @(posedge sys_clk) begin
		osc_cnt <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
		osc_tick <= (osc_cnt == 2'h2);
	end

	cbt_bit_timing_config cbt_bit_timing_config_inst (
		.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .osc_tick(osc_tick), .can_rx(can_rx),
		.wakeup_evt(wakeup_evt), .status_change_evt(status_change_evt),
		.overrun_evt(overrun_evt), .rx_full_evt(rx_full_evt),
		.rx_state_in(rx_state_in), .tx_state_in(tx_state_in),
		.irq(irq), .init_mode(init_mode), .tq_tick(tq_tick),
		.sample_point(sample_point), .bit_start(bit_start), .rx_bit(rx_bit)
	);

	cbt_bus_node cbt_bus_node_inst (
		.sys_clk(sys_clk), .rst_n(reset_n), .mode(bus_mode), .can_rx(can_rx)
	);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] seen,
			input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk("read data", reg_rdata, exp);
	endtask

	// sel 0 waits a quantum tick, 1 a bit start, 2 a sample point
	task automatic wait_pulse(input int sel);
		do begin
			@(posedge sys_clk);
			#1;
		end while ((sel == 0 ? tq_tick : sel == 1 ? bit_start
				: sample_point) !== 1'b1);
	endtask

	task automatic gap(input int sel, output logic [7:0] cnt);
		wait_pulse(sel);
		cnt = 8'h00;
		do begin
			@(posedge sys_clk);
			#1;
			cnt++;
		end while ((sel == 0 ? tq_tick : bit_start) !== 1'b1);
	endtask

	task automatic set_init(input logic [7:0] ctrl);
		wr(8'h00, ctrl);
		repeat (4) @(posedge sys_clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_and_lock();
		rd(8'h02, 8'h00);
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h07, 8'h00);
		wr(8'h02, 8'h55);
		rd(8'h02, 8'h00);
		wr(8'h03, 8'hAA);
		rd(8'h03, 8'h00);
	endtask

	task automatic t_config_timing();
		set_init(8'h03);
		#1 chk("init mode", {7'h00, init_mode}, 8'h01);
		rd(8'h01, 8'h01);
		wr(8'h02, 8'hC1);
		// single sampling, seg1 four quanta, seg2 two quanta
		wr(8'h03, 8'h13);
		rd(8'h02, 8'hC1);
		rd(8'h03, 8'h13);
		set_init(8'h02);
		#1 chk("init mode off", {7'h00, init_mode}, 8'h00);
		gap(0, n);
		chk("quantum gap", n, 8'h02);
		gap(0, n);
		chk("quantum gap", n, 8'h02);
		gap(1, n);
		chk("bit gap", n, 8'h0E);
	endtask

	task automatic t_single_sample();
		@(posedge sys_clk);
		bus_mode <= 2'h1;
		wait_pulse(2);
		wait_pulse(2);
		chk("dominant bit", {7'h00, rx_bit}, 8'h00);
		@(posedge sys_clk);
		bus_mode <= 2'h0;
		wait_pulse(2);
		wait_pulse(2);
		chk("recessive bit", {7'h00, rx_bit}, 8'h01);
	endtask

	task automatic t_flags();
		wr(8'h05, 8'h03);
		rx_full_evt <= 1'b1;
		@(posedge sys_clk);
		rx_full_evt <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 chk("irq full", {7'h00, irq}, 8'h01);
		rd(8'h04, 8'h01);
		@(posedge sys_clk);
		overrun_evt <= 1'b1;
		wr(8'h04, 8'h02);
		rd(8'h04, 8'h03);
		@(posedge sys_clk);
		overrun_evt <= 1'b0;
		wr(8'h04, 8'h00);
		rd(8'h04, 8'h03);
		wr(8'h05, 8'h02);
		wr(8'h04, 8'h02);
		rd(8'h04, 8'h01);
		repeat (2) @(posedge sys_clk);
		#1 chk("irq masked", {7'h00, irq}, 8'h00);
		wr(8'h04, 8'h01);
		rd(8'h04, 8'h00);
		@(posedge sys_clk);
		rx_state_in <= 2'h2;
		tx_state_in <= 2'h1;
		wakeup_evt <= 1'b1;
		status_change_evt <= 1'b1;
		@(posedge sys_clk);
		wakeup_evt <= 1'b0;
		status_change_evt <= 1'b0;
		rx_state_in <= 2'h1;
		tx_state_in <= 2'h2;
		rd(8'h04, 8'hE4);
		wr(8'h04, 8'h3C);
		rd(8'h04, 8'hE4);
		wr(8'h04, 8'hC0);
		rd(8'h04, 8'h18);
	endtask

	task automatic t_triple_sample();
		set_init(8'h03);
		// seg1 of four quanta leaves phase segment room for three samples
		// triple sampling with long phase segment
		wr(8'h03, 8'h93);
		set_init(8'h02);
		bus_mode <= 2'h2;
		wait_pulse(2);
		wait_pulse(2);
		for (int i = 0; i < 6; i++) begin
			wait_pulse(2);
			chk("majority bit", {7'h00, rx_bit}, 8'h00);
		end
		@(posedge sys_clk);
		bus_mode <= 2'h0;
	endtask

	task automatic t_osc_source();
		set_init(8'h01);
		// back to single sampling for the faster check
		wr(8'h03, 8'h13);
		set_init(8'h00);
		gap(0, n);
		chk("osc quantum gap", n, 8'h06);
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ceiling well above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	initial begin
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_reset_and_lock();
		t_config_timing();
		t_single_sample();
		t_flags();
		t_triple_sample();
		t_osc_source();
		wrap_up();
	end
endmodule
`default_nettype wire
